// ### src/dio_pkg.sv
// Constants shared by the drive I/O mapping block
package dio_pkg;
    // ------------------------------------------------------------
    // Widths and storage
    // ------------------------------------------------------------
    localparam int DW = 16;
    localparam int AW = 5;
    localparam int NCFG = 18;
    localparam int FRAC = 8;

    // ------------------------------------------------------------
    // Register indices (word addresses on the register port)
    // ------------------------------------------------------------
    localparam logic [AW-1:0] R_VI_LO_V = 5'h00;
    localparam logic [AW-1:0] R_VI_LO_PCT = 5'h01;
    localparam logic [AW-1:0] R_VI_HI_V = 5'h02;
    localparam logic [AW-1:0] R_VI_HI_PCT = 5'h03;
    localparam logic [AW-1:0] R_CI_LO_V = 5'h04;
    localparam logic [AW-1:0] R_CI_LO_PCT = 5'h05;
    localparam logic [AW-1:0] R_CI_HI_V = 5'h06;
    localparam logic [AW-1:0] R_CI_HI_PCT = 5'h07;
    localparam logic [AW-1:0] R_CI_FILT = 5'h08;
    localparam logic [AW-1:0] R_CO1_SEL = 5'h09;
    localparam logic [AW-1:0] R_CO2_SEL = 5'h0A;
    localparam logic [AW-1:0] R_RLY_SEL = 5'h0B;
    localparam logic [AW-1:0] R_MTR_SEL = 5'h0C;
    localparam logic [AW-1:0] R_AO_LO_PCT = 5'h0D;
    localparam logic [AW-1:0] R_AO_LO_V = 5'h0E;
    localparam logic [AW-1:0] R_AO_HI_PCT = 5'h0F;
    localparam logic [AW-1:0] R_AO_HI_V = 5'h10;
    localparam logic [AW-1:0] R_MODE = 5'h11;
    localparam logic [AW-1:0] R_STATUS = 5'h12;
    localparam logic [AW-1:0] R_VI_SET = 5'h13;
    localparam logic [AW-1:0] R_CI_SET = 5'h14;
    localparam logic [AW-1:0] R_MTR_LVL = 5'h15;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MODE_CI_CUR = 0;
    localparam int MODE_MTR_CUR = 1;
    localparam int MODE_W = 2;
    localparam int ST_CO1 = 0;
    localparam int ST_CO2 = 1;
    localparam int ST_RLY = 2;

    // ------------------------------------------------------------
    // Values: volts in 0.01 V, percent in 0.1 %, time in 0.01 s
    // ------------------------------------------------------------
    localparam logic [DW-1:0] V_FULL = 16'h03E8;
    localparam logic [DW-1:0] PCT_FULL = 16'h03E8;
    localparam logic [DW-1:0] PCT_NEG_FULL = 16'hFC18;
    localparam logic [DW-1:0] FILT_MAX_CS = 16'h03E8;
    localparam logic [DW-1:0] FILT_DEF_CS = 16'h000A;
    localparam logic [DW-1:0] SEL_MAX = 16'h000A;
    localparam logic [DW-1:0] SEL_DEF_CO1 = 16'h0001;
    localparam logic [DW-1:0] SEL_DEF_CO2 = 16'h0002;
    localparam logic [DW-1:0] SEL_DEF_RLY = 16'h0003;
    localparam logic [DW-1:0] ZERO = 16'h0000;

    // ------------------------------------------------------------
    // Selector codes
    // ------------------------------------------------------------
    localparam int SEL_FREQ_OK = 1;
    localparam int SEL_FDT = 2;
    localparam int SEL_FAULT = 3;
    localparam int SEL_FWD = 4;
    localparam int SEL_REV = 5;
    localparam int SEL_NULL = 6;
    localparam int SEL_UPPER = 7;
    localparam int SEL_LOWER = 8;
    localparam int NSEL = 11;
    localparam logic [3:0] M_SET_FREQ = 4'h0;
    localparam logic [3:0] M_RUN_FREQ = 4'h1;
    localparam logic [3:0] M_CURRENT = 4'h2;
    localparam logic [3:0] M_VOLTAGE = 4'h3;
    localparam logic [3:0] M_SPEED = 4'h4;
    localparam logic [3:0] M_POWER = 4'h5;
    localparam logic [3:0] M_TORQUE = 4'h6;
    localparam logic [3:0] M_VI = 4'h7;
    localparam logic [3:0] M_CI = 4'h8;

    // ------------------------------------------------------------
    // Scaling and timing
    // ------------------------------------------------------------
    localparam int RATED_MULT = 2;
    localparam int CUR_PER_V = 2;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int TICK_PS = 1000000000;
    localparam int TICK_CYCLES = TICK_PS / CLK_PERIOD_PS;
    localparam int FILT_UNIT_MS = 10;
    localparam int TICK_MS = 1;
    localparam int TICKS_PER_UNIT = FILT_UNIT_MS / TICK_MS;
endpackage : dio_pkg

// ### src/dio_map_if.sv
// Signals of one clamped two-point linear mapping
`timescale 1ns/1ps
interface dio_map_if;
    logic signed [15:0] x;
    logic signed [15:0] x_lo;
    logic signed [15:0] x_hi;
    logic signed [15:0] y_lo;
    logic signed [15:0] y_hi;
    logic signed [15:0] y;
    modport src (output x, output x_lo, output x_hi, output y_lo,
                 output y_hi, input y);
    modport map (input x, input x_lo, input x_hi, input y_lo,
                 input y_hi, output y);
endinterface : dio_map_if

// ### src/dio_map.sv
// Clamped two-point linear mapping
`timescale 1ns/1ps
module dio_map (
    dio_map_if.map m // Points in, mapped value out
);
    int xc;
    int span;
    int prod;

    always_comb begin
        xc = int'(m.x);
        if (xc < int'(m.x_lo)) begin
            xc = int'(m.x_lo);
        end
        if (xc > int'(m.x_hi)) begin
            xc = int'(m.x_hi);
        end
        span = int'(m.x_hi) - int'(m.x_lo);
        prod = (xc - int'(m.x_lo)) * (int'(m.y_hi) - int'(m.y_lo));
        // Degenerate span: step at the single point
        if (span <= 0) begin
            m.y = (int'(m.x) <= int'(m.x_lo)) ? m.y_lo : m.y_hi;
        end else begin
            m.y = 16'(int'(m.y_lo) + prod / span);
        end
    end
endmodule : dio_map

// ### src/dio_lpf.sv
// First-order low-pass filter stepped by a tick
`timescale 1ns/1ps
module dio_lpf #(
    parameter int W = 16
) (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic tick, // One-cycle step pulse
    input wire logic [15:0] tau, // Filter time, 0.01 s units
    input wire logic signed [W-1:0] x, // Sample in
    output logic signed [W-1:0] y // Filtered value
);
    typedef struct packed {
        logic signed [W+dio_pkg::FRAC-1:0] acc;
    } dio_lpf_s;

    dio_lpf_s s_r;
    dio_lpf_s s_nxt;
    logic signed [W+dio_pkg::FRAC:0] diff;
    int den;

    always_comb begin
        s_nxt = s_r;
        diff = (W+dio_pkg::FRAC+1)'(x <<< dio_pkg::FRAC)
             - (W+dio_pkg::FRAC+1)'(s_r.acc);
        den = int'(tau) * dio_pkg::TICKS_PER_UNIT;
        if (tick) begin
            // Zero time passes the sample straight through
            if (tau == dio_pkg::ZERO) begin
                s_nxt.acc = x <<< dio_pkg::FRAC;  // RULE2
            end else begin
                s_nxt.acc = s_r.acc
                    + (W+dio_pkg::FRAC)'(int'(diff) / den); // RULE2
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign y = s_r.acc[W+dio_pkg::FRAC-1:dio_pkg::FRAC];
endmodule : dio_lpf

// ### src/dio_top.sv
// Drive I/O mapping: analog inputs, digital outputs, meter output
// What this block does
// RULE1: Holds voltage and percent points per input
// RULE2: Low-pass filters current input, settable time
// RULE3: Current input uses same two-point mapping
// RULE4: Out-of-range input clamps to nearer point
// RULE5: Current mode treats 20 mA as 10 V
// RULE6: Three selectors, codes 0..10, defaults 1,2,3
// RULE7: Code 0 keeps output off
// RULE8: Codes 1,2 follow frequency and level flags
// RULE9: Code 3 follows drive fault
// RULE10: Codes 4,5 follow forward, reverse running
// RULE11: Code 6 on below starting frequency
// RULE12: Codes 7,8 on at frequency limits
// RULE13: Codes 9,10 act like code 0
// RULE14: Meter codes 0,1 scale to maximum frequency
// RULE15: Codes 2..6 scale to twice rated value
// RULE16: Codes 7,8 pass the analog inputs
// RULE17: Meter mapping points, percent to volts
// RULE18: Linear interpolation between meter points
// RULE19: Meter source clamps to nearer point
// RULE20: Current output: 1 mA per 0.5 V
`timescale 1ns/1ps
module dio_top #(
    parameter int TICK_CYCLES = dio_pkg::TICK_CYCLES
) (
    input wire logic clk_sys, // 125 MHz system clock
    input wire logic rstn, // Async reset, active low
    input wire logic [4:0] reg_addr, // Register index
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [15:0] reg_rdata, // Read data, next cycle
    input wire logic [15:0] vi_adc, // Voltage input, 0.01 V
    input wire logic [15:0] ci_v_adc, // Current input as volts
    input wire logic [15:0] ci_ma_adc, // Current input, 0.01 mA
    input wire logic freq_reached, // Frequency reached
    input wire logic fdt_reached, // Detect level reached
    input wire logic drive_fault, // Drive in fault
    input wire logic run_fwd, // Running forward
    input wire logic run_rev, // Running reverse
    input wire logic [15:0] out_freq, // Output frequency
    input wire logic [15:0] set_freq, // Set frequency
    input wire logic [15:0] start_freq, // Starting frequency
    input wire logic [15:0] upper_freq, // Upper limit frequency
    input wire logic [15:0] lower_freq, // Lower limit frequency
    input wire logic [15:0] max_freq, // Maximum output frequency
    input wire logic [15:0] out_current, // Output current
    input wire logic [15:0] rated_current, // Rated drive current
    input wire logic [15:0] out_voltage, // Output voltage
    input wire logic [15:0] rated_voltage, // Rated drive voltage
    input wire logic [15:0] motor_speed, // Motor speed
    input wire logic [15:0] rated_speed, // Rated motor speed
    input wire logic [15:0] out_power, // Output power
    input wire logic [15:0] rated_power, // Rated power
    input wire logic [15:0] out_torque, // Torque current
    input wire logic [15:0] rated_motor_cur, // Rated motor current
    output logic collector_output_one, // Collector output 1
    output logic collector_output_two, // Collector output 2
    output logic relay_output, // Relay drive
    output logic [15:0] analog_meter_level, // Meter, 0.01 V
    output logic [15:0] analog_meter_ma, // Meter, 0.01 mA
    output logic meter_current_mode, // Meter in current mode
    output logic signed [15:0] vi_setting, // Voltage input, 0.1 %
    output logic signed [15:0] ci_setting // Current input, 0.1 %
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [dio_pkg::NCFG-1:0][15:0] cfg;
        logic [15:0] rdata;
        logic co1;
        logic co2;
        logic rly;
        logic [15:0] mlvl;
        logic [15:0] mma;
        logic signed [15:0] vi_set;
        logic signed [15:0] ci_set;
        logic [31:0] tick_cnt;
        logic tick;
    } dio_state_s;

    dio_state_s s_r;
    dio_state_s s_nxt;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [15:0] rst_val(input int i);
        logic [15:0] v;
        v = dio_pkg::ZERO;
        case (5'(i))
            dio_pkg::R_VI_HI_V: v = dio_pkg::V_FULL;
            dio_pkg::R_VI_HI_PCT: v = dio_pkg::PCT_FULL;
            dio_pkg::R_CI_HI_V: v = dio_pkg::V_FULL;
            dio_pkg::R_CI_HI_PCT: v = dio_pkg::PCT_FULL;
            dio_pkg::R_CI_FILT: v = dio_pkg::FILT_DEF_CS;
            dio_pkg::R_CO1_SEL: v = dio_pkg::SEL_DEF_CO1;
            dio_pkg::R_CO2_SEL: v = dio_pkg::SEL_DEF_CO2;
            dio_pkg::R_RLY_SEL: v = dio_pkg::SEL_DEF_RLY;
            dio_pkg::R_AO_HI_PCT: v = dio_pkg::PCT_FULL;
            dio_pkg::R_AO_HI_V: v = dio_pkg::V_FULL;
            default: v = dio_pkg::ZERO;
        endcase
        return v;
    endfunction : rst_val

    // Out-of-range writes are dropped, keeping the old setting
    function automatic logic wr_ok(input logic [4:0] a,
                                   input logic [15:0] d);
        logic ok;
        ok = 1'b0;
        case (a)
            dio_pkg::R_VI_LO_V, dio_pkg::R_VI_HI_V,
            dio_pkg::R_CI_LO_V, dio_pkg::R_CI_HI_V,
            dio_pkg::R_AO_LO_V, dio_pkg::R_AO_HI_V:
                ok = d <= dio_pkg::V_FULL;
            dio_pkg::R_VI_LO_PCT, dio_pkg::R_VI_HI_PCT,
            dio_pkg::R_CI_LO_PCT, dio_pkg::R_CI_HI_PCT:
                ok = $signed(d) <= $signed(dio_pkg::PCT_FULL) &&
                     $signed(d) >= $signed(dio_pkg::PCT_NEG_FULL);
            dio_pkg::R_AO_LO_PCT, dio_pkg::R_AO_HI_PCT:
                ok = d <= dio_pkg::PCT_FULL;
            dio_pkg::R_CI_FILT:
                ok = d <= dio_pkg::FILT_MAX_CS;
            dio_pkg::R_CO1_SEL, dio_pkg::R_CO2_SEL,
            dio_pkg::R_RLY_SEL, dio_pkg::R_MTR_SEL:
                ok = d <= dio_pkg::SEL_MAX;
            dio_pkg::R_MODE: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : wr_ok

    // Value as 0.1 % of full scale, capped at 100 %
    function automatic logic signed [15:0] pct_of(
        input logic [15:0] val, input int full);
        int p;
        p = 0;
        if (full > 0) begin
            p = int'(val) * int'(dio_pkg::PCT_FULL) / full;
        end
        if (p > int'(dio_pkg::PCT_FULL)) begin
            p = int'(dio_pkg::PCT_FULL);
        end
        return 16'(p);
    endfunction : pct_of

    // Selectors outside 0..10 cannot be stored; 9, 10 find 0
    function automatic logic sel_out(input logic [15:0] sel,
                                     input logic [10:0] st);
        return (sel <= dio_pkg::SEL_MAX) ? st[sel[3:0]] : 1'b0;
    endfunction : sel_out

    // ------------------------------------------------------------
    // Analog input path
    // ------------------------------------------------------------
    dio_map_if vi_if ();
    dio_map_if ci_if ();
    dio_map_if ao_if ();
    logic [15:0] ci_raw;
    logic signed [15:0] ci_filt;
    logic [10:0] st;
    logic signed [15:0] src_pct;
    logic [3:0] msel;

    // Current mode halves 0.01 mA so 20 mA reads as 10 V
    assign ci_raw = s_r.cfg[dio_pkg::R_MODE][dio_pkg::MODE_CI_CUR]
        ? 16'(int'(ci_ma_adc) / dio_pkg::CUR_PER_V) // RULE5
        : ci_v_adc;

    dio_lpf #(.W(16)) u_ci_lpf (
        .clk_sys (clk_sys),
        .rstn (rstn),
        .tick (s_r.tick),
        .tau (s_r.cfg[dio_pkg::R_CI_FILT]),
        .x (ci_raw),
        .y (ci_filt)
    );

    assign vi_if.x = vi_adc;
    assign vi_if.x_lo = s_r.cfg[dio_pkg::R_VI_LO_V]; // RULE1
    assign vi_if.x_hi = s_r.cfg[dio_pkg::R_VI_HI_V];
    assign vi_if.y_lo = s_r.cfg[dio_pkg::R_VI_LO_PCT];
    assign vi_if.y_hi = s_r.cfg[dio_pkg::R_VI_HI_PCT];
    assign ci_if.x = ci_filt; // RULE3
    assign ci_if.x_lo = s_r.cfg[dio_pkg::R_CI_LO_V]; // RULE1
    assign ci_if.x_hi = s_r.cfg[dio_pkg::R_CI_HI_V];
    assign ci_if.y_lo = s_r.cfg[dio_pkg::R_CI_LO_PCT];
    assign ci_if.y_hi = s_r.cfg[dio_pkg::R_CI_HI_PCT];

    dio_map u_vi_map (.m (vi_if.map)); // RULE4
    dio_map u_ci_map (.m (ci_if.map)); // RULE3

    // ------------------------------------------------------------
    // Meter source and output mapping
    // ------------------------------------------------------------
    assign msel = s_r.cfg[dio_pkg::R_MTR_SEL][3:0];

    always_comb begin
        case (msel)
            dio_pkg::M_SET_FREQ:
                src_pct = pct_of(set_freq, int'(max_freq)); // RULE14
            dio_pkg::M_RUN_FREQ:
                src_pct = pct_of(out_freq, int'(max_freq)); // RULE14
            dio_pkg::M_CURRENT: src_pct = pct_of(out_current,
                dio_pkg::RATED_MULT * int'(rated_current)); // RULE15
            dio_pkg::M_VOLTAGE: src_pct = pct_of(out_voltage,
                dio_pkg::RATED_MULT * int'(rated_voltage)); // RULE15
            dio_pkg::M_SPEED: src_pct = pct_of(motor_speed,
                dio_pkg::RATED_MULT * int'(rated_speed)); // RULE15
            dio_pkg::M_POWER: src_pct = pct_of(out_power,
                dio_pkg::RATED_MULT * int'(rated_power)); // RULE15
            dio_pkg::M_TORQUE: src_pct = pct_of(out_torque,
                dio_pkg::RATED_MULT * int'(rated_motor_cur)); // RULE15
            dio_pkg::M_VI:
                src_pct = pct_of(vi_adc, int'(dio_pkg::V_FULL)); // RULE16
            dio_pkg::M_CI:
                src_pct = pct_of(ci_raw, int'(dio_pkg::V_FULL)); // RULE16
            default: src_pct = '0;
        endcase
    end

    assign ao_if.x = src_pct;
    assign ao_if.x_lo = s_r.cfg[dio_pkg::R_AO_LO_PCT]; // RULE17
    assign ao_if.x_hi = s_r.cfg[dio_pkg::R_AO_HI_PCT];
    assign ao_if.y_lo = s_r.cfg[dio_pkg::R_AO_LO_V];
    assign ao_if.y_hi = s_r.cfg[dio_pkg::R_AO_HI_V];

    dio_map u_ao_map (.m (ao_if.map)); // RULE18 RULE19

    // ------------------------------------------------------------
    // Digital output functions, indexed by selector code
    // ------------------------------------------------------------
    always_comb begin
        st = '0; // RULE7 RULE13
        st[dio_pkg::SEL_FREQ_OK] = freq_reached; // RULE8
        st[dio_pkg::SEL_FDT] = fdt_reached; // RULE8
        st[dio_pkg::SEL_FAULT] = drive_fault; // RULE9
        st[dio_pkg::SEL_FWD] = run_fwd && out_freq != '0; // RULE10
        st[dio_pkg::SEL_REV] = run_rev && out_freq != '0; // RULE10
        st[dio_pkg::SEL_NULL] = out_freq < start_freq; // RULE11
        st[dio_pkg::SEL_UPPER] = out_freq >= upper_freq; // RULE12
        st[dio_pkg::SEL_LOWER] = out_freq <= lower_freq; // RULE12
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            s_nxt.tick_cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 32'h00000001;
        end
        if (reg_wr && int'(reg_addr) < dio_pkg::NCFG &&
            wr_ok(reg_addr, reg_wdata)) begin
            s_nxt.cfg[reg_addr] = reg_wdata; // RULE6
        end
        if (reg_rd) begin
            case (reg_addr)
                dio_pkg::R_STATUS:
                    s_nxt.rdata = {13'h0000, s_r.rly, s_r.co2, s_r.co1};
                dio_pkg::R_VI_SET: s_nxt.rdata = s_r.vi_set;
                dio_pkg::R_CI_SET: s_nxt.rdata = s_r.ci_set;
                dio_pkg::R_MTR_LVL: s_nxt.rdata = s_r.mlvl;
                default: begin
                    s_nxt.rdata = (int'(reg_addr) < dio_pkg::NCFG)
                        ? s_r.cfg[reg_addr] : dio_pkg::ZERO;
                end
            endcase
        end
        s_nxt.co1 = sel_out(s_r.cfg[dio_pkg::R_CO1_SEL], st); // RULE6
        s_nxt.co2 = sel_out(s_r.cfg[dio_pkg::R_CO2_SEL], st);
        s_nxt.rly = sel_out(s_r.cfg[dio_pkg::R_RLY_SEL], st);
        s_nxt.vi_set = vi_if.y;
        s_nxt.ci_set = ci_if.y;
        s_nxt.mlvl = ao_if.y;
        s_nxt.mma = 16'(int'(ao_if.y) * dio_pkg::CUR_PER_V); // RULE20
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
            for (int i = 0; i < dio_pkg::NCFG; i++) begin
                s_r.cfg[i] <= rst_val(i);
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign collector_output_one = s_r.co1;
    assign collector_output_two = s_r.co2;
    assign relay_output = s_r.rly;
    assign analog_meter_level = s_r.mlvl;
    assign analog_meter_ma = s_r.mma;
    assign meter_current_mode =
        s_r.cfg[dio_pkg::R_MODE][dio_pkg::MODE_MTR_CUR];
    assign vi_setting = s_r.vi_set;
    assign ci_setting = s_r.ci_set;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_sel_in_range: assert property ( // RULE6
        s_r.cfg[dio_pkg::R_CO1_SEL] <= dio_pkg::SEL_MAX &&
        s_r.cfg[dio_pkg::R_RLY_SEL] <= dio_pkg::SEL_MAX)
        else $error("output selector above 10");
    a_off_codes: assert property ( // RULE13
        (s_r.cfg[dio_pkg::R_CO1_SEL] == dio_pkg::ZERO ||
         s_r.cfg[dio_pkg::R_CO1_SEL] > 16'h0008) |=> !s_r.co1)
        else $error("collector one on for off code");
    a_fault_output: assert property ( // RULE9
        s_r.cfg[dio_pkg::R_RLY_SEL] == 16'h0003 && drive_fault
        |=> s_r.rly)
        else $error("relay missed drive fault");
    a_fwd_running: assert property ( // RULE10
        s_r.cfg[dio_pkg::R_CO2_SEL] == 16'h0004
        |=> s_r.co2 == ($past(run_fwd) && $past(out_freq) != '0))
        else $error("forward running output wrong");
    a_null_speed: assert property ( // RULE11
        s_r.cfg[dio_pkg::R_CO1_SEL] == 16'h0006 &&
        out_freq < start_freq |=> s_r.co1)
        else $error("null speed output missed");
    a_meter_bounds: assert property ( // RULE19
        // Level lags its points by one cycle
        (s_r.mlvl == $past(s_r.cfg[dio_pkg::R_AO_LO_V]) ||
         s_r.mlvl == $past(s_r.cfg[dio_pkg::R_AO_HI_V])) ||
        (s_r.mlvl >= $past(s_r.cfg[dio_pkg::R_AO_LO_V])) !=
        (s_r.mlvl > $past(s_r.cfg[dio_pkg::R_AO_HI_V])))
        else $error("meter level outside its points");
    a_meter_ma: assert property ( // RULE20
        ##1 s_r.mma == 16'(int'(s_r.mlvl) * dio_pkg::CUR_PER_V))
        else $error("meter current not twice voltage");
    a_vi_clamp: assert property ( // RULE4
        vi_adc > s_r.cfg[dio_pkg::R_VI_HI_V] && $stable(s_r.cfg)
        |=> s_r.vi_set == $signed($past(s_r.cfg[dio_pkg::R_VI_HI_PCT])))
        else $error("voltage input not clamped high");
    a_tick_period: assert property ( // RULE2
        s_r.tick |=> !s_r.tick [*2])
        else $error("filter tick too frequent");
endmodule : dio_top

// ### dv/dio_plant.sv
// Drive-side status and measurements seen by the mapping block
`timescale 1ns/1ps
module dio_plant (
    input wire logic cond, // Make every output condition true
    input wire logic [15:0] lvl, // Level reported by the drive
    output logic [4:0] flg, // fault, fwd, rev, freq, detect flags
    output logic [15:0] frq [6], // out, set, start, upper, lower, max
    output logic [15:0] meas, // Measured quantities
    output logic [15:0] rated // Rated values, half of full scale
);
    // With cond, frequency 5 sits below start (10) and at upper and lower limits together
    always_comb begin
        flg = {5{cond}};
        frq[0] = 16'h0005;
        frq[1] = lvl;
        frq[2] = cond ? 16'h000A : 16'h0000;
        frq[3] = cond ? 16'h0005 : 16'h0064;
        frq[4] = cond ? 16'h0005 : 16'h0000;
        frq[5] = 16'h03E8;
        meas = lvl;
        rated = 16'h01F4;
    end
endmodule : dio_plant

// ### dv/dio_top_tb_top.sv
// Self-checking bench for the drive I/O mapping block
`timescale 1ns/1ps
module dio_top_tb_top;
    logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, lvl = 16'h0000, vi_adc = 16'h0000;
    logic [15:0] ci_v_adc = 16'h0000, ci_ma_adc = 16'h0000, reg_rdata;
    logic [15:0] frq [6], meas, rated, analog_meter_level, analog_meter_ma;
    logic [4:0] flg;
    logic cond = 1'b0, collector_output_one, collector_output_two;
    logic relay_output, meter_current_mode;
    logic signed [15:0] vi_setting, ci_setting;
    int miscompares = 0;
    int samples_checked = 0;
    always #4 clk_sys = ~clk_sys;
    dio_plant PLANT (.cond, .lvl, .flg, .frq, .meas, .rated);
    dio_top #(.TICK_CYCLES(10)) DUT (.clk_sys, .rstn, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .vi_adc, .ci_v_adc, .ci_ma_adc,
        .drive_fault(flg[0]), .run_fwd(flg[1]), .run_rev(flg[2]),
        .freq_reached(flg[3]), .fdt_reached(flg[4]), .out_freq(frq[0]),
        .set_freq(frq[1]), .start_freq(frq[2]), .upper_freq(frq[3]),
        .lower_freq(frq[4]), .max_freq(frq[5]), .out_current(meas),
        .rated_current(rated), .out_voltage(meas), .rated_voltage(rated),
        .motor_speed(meas), .rated_speed(rated), .out_power(meas),
        .rated_power(rated), .out_torque(meas), .rated_motor_cur(rated),
        .collector_output_one, .collector_output_two, .relay_output,
        .analog_meter_level, .analog_meter_ma, .meter_current_mode,
        .vi_setting, .ci_setting);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    task automatic settle;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : settle
    task automatic t_defaults;
        wr(dio_pkg::R_CO1_SEL, 16'h000B);
        rd(dio_pkg::R_CO1_SEL, 16'h0001);
        rd(dio_pkg::R_CO2_SEL, 16'h0002);
        rd(dio_pkg::R_RLY_SEL, 16'h0003);
        rd(dio_pkg::R_CI_FILT, 16'h000A);
        rd(dio_pkg::R_MTR_SEL, 16'h0000);
        rd(dio_pkg::R_CI_HI_V, 16'h03E8);
        rd(dio_pkg::R_AO_HI_V, 16'h03E8);
        rd(5'h1F, 16'h0000);
    endtask : t_defaults
    task automatic t_select;
        logic e;
        for (int c = 0; c <= 10; c++) begin
            wr(dio_pkg::R_CO1_SEL, 16'(c));
            wr(dio_pkg::R_CO2_SEL, 16'(c));
            wr(dio_pkg::R_RLY_SEL, 16'(c));
            for (int k = 0; k < 2; k++) begin
                cond <= k[0];
                settle();
                e = k[0] && c >= 1 && c <= 8;
                chk({13'h0, relay_output, collector_output_two,
                    collector_output_one}, {13'h0, {3{e}}});
                rd(dio_pkg::R_STATUS, {13'h0, {3{e}}});
                chk({15'h0, collector_output_one}, {15'h0, e});
                chk({15'h0, relay_output}, {15'h0, e});
            end
        end
    endtask : t_select
    task automatic t_meter;
        int p;
        logic [15:0] e;
        wr(dio_pkg::R_AO_LO_PCT, 16'h00C8);
        wr(dio_pkg::R_AO_LO_V, 16'h0064);
        wr(dio_pkg::R_AO_HI_PCT, 16'h0320);
        wr(dio_pkg::R_AO_HI_V, 16'h02BC);
        wr(dio_pkg::R_MODE, 16'h0002);
        for (int c = 0; c <= 10; c++) begin
            wr(dio_pkg::R_MTR_SEL, 16'(c));
            for (int i = 0; i < 3 && c != 1; i++) begin
                {lvl, vi_adc, ci_v_adc} <= {3{16'(i * 450)}};
                settle();
                p = (c >= 9) ? 0 : i * 450;
                e = (p < 200) ? 16'h0064 : (p > 800) ? 16'h02BC : 16'(p - 100);
                chk(analog_meter_level, e);
                rd(dio_pkg::R_MTR_LVL, e);
                chk(analog_meter_ma, 16'(2 * e));
                chk({15'h0, meter_current_mode}, 16'h0001);
            end
        end
    endtask : t_meter
    task automatic t_inputs;
        wr(dio_pkg::R_VI_LO_V, 16'h00C8);
        wr(dio_pkg::R_VI_LO_PCT, 16'hFE0C);
        wr(dio_pkg::R_VI_HI_V, 16'h0258);
        wr(dio_pkg::R_VI_HI_PCT, 16'h01F4);
        vi_adc <= 16'h0064;
        settle();
        chk(vi_setting, 16'hFE0C);
        vi_adc <= 16'h0190;
        settle();
        chk(vi_setting, 16'h0000);
        vi_adc <= 16'h0384;
        settle();
        chk(vi_setting, 16'h01F4);
        wr(dio_pkg::R_CI_FILT, 16'h0000);
        wr(dio_pkg::R_MODE, 16'h0001);
        ci_ma_adc <= 16'h03E8;
        repeat (10) settle();
        chk(ci_setting, 16'h01F4);
        wr(dio_pkg::R_CI_FILT, 16'h000A);
        ci_ma_adc <= 16'h0000;
        repeat (8) settle();
        chk({15'h0, ci_setting > 0 && ci_setting < 16'sh01F4}, 16'h0001);
    endtask : t_inputs
    task automatic end_of_test;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        t_defaults();
        t_select();
        t_meter();
        t_inputs();
        end_of_test();
    end
    // Whole run needs about 550 cycles
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
endmodule : dio_top_tb_top
